// ===== ebsc_bus_ctrl.v
// external bus strobe controller: address latch, read and write strobes
//
// Contract
// RULE1 - eight-pin port, each pin input or output by its direction bit
// RULE2 - pins set as input have their driver off
// RULE3 - port optionally carries address bits 16..23, bit 0 is bit 16
// RULE4 - read strobe asserted on every external instruction or data read
// RULE5 - word write mode: write strobe on every external data write
// RULE6 - byte mode: strobe on low-byte writes, or any write on 8-bit bus
// RULE7 - write strobe mode chosen by config field of system config register
// RULE8 - ready high during access inserts wait states until it goes low
// RULE9 - address latch enable driven in multiplexed bus modes
// RULE10 - low fetch select at reset means external fetch, high internal
// RULE11 - second output serves as high-byte enable or high-byte strobe; here two outputs, high_byte_enable_n and high_byte_write_strobe_n
// RULE12 - read, write strobes and fetch select are active low
`timescale 1ns/1ns
`default_nettype none
`include "ebsc_defines.vh"
module ebsc_bus_ctrl #(
	parameter AW = 24,
	parameter PW = `EBSC_PORT_W
) (
	input wire mclk,
	input wire rstn,
	input wire req,
	input wire req_write,
	input wire req_fetch,
	input wire [AW-1:0] req_addr,
	input wire [1:0] req_bytes,
	input wire bus_8bit,
	input wire bus_mux,
	input wire ready_enable,
	input wire [15:0] system_config_register,
	input wire [PW-1:0] port_dir,
	input wire [PW-1:0] port_data,
	input wire [PW-1:0] seg_sel,
	input wire ready,
	input wire external_fetch_select_n,
	input wire [PW-1:0] segment_address_port_in,
	output wire [PW-1:0] segment_address_port_out,
	output wire [PW-1:0] segment_address_port_oe,
	output wire [PW-1:0] port_value,
	output reg [AW-1:0] addr_out,
	output reg ale,
	output reg read_strobe_n,
	output reg low_byte_write_strobe_n,
	output reg high_byte_enable_n,
	output reg high_byte_write_strobe_n,
	output wire busy,
	output reg done,
	output wire fetch_external
);
	// one config register bit selects the write strobe meaning
	localparam CFG_WR_BIT = `EBSC_WRITE_STROBE_CONFIG_BIT;
	reg [`EBSC_ST_W-1:0] state;
	reg [`EBSC_ST_W-1:0] next_state;
	reg op_write;
	reg op_8bit;
	reg [1:0] op_bytes;
	wire write_strobe_config;

	assign write_strobe_config = system_config_register[CFG_WR_BIT]; // [RULE7]
	assign busy = (state != `EBSC_ST_IDLE);

	// low-byte strobe decode by write strobe meaning
	function low_active;
		input cfg;
		input b8;
		input [1:0] bytes;
		begin
			if (cfg == `EBSC_WRITE_STROBE_CONFIG_WORD)
				low_active = 1'h1; // [RULE5]
			else
				low_active = b8 | bytes[0]; // [RULE6]
		end
	endfunction

	ebsc_seg_port #(.W(PW)) u_port (
		.mclk(mclk),
		.rstn(rstn),
		.dir_out(port_dir),
		.port_data(port_data),
		.seg_sel(seg_sel),
		.seg_addr(addr_out[`EBSC_SEG_MSB:`EBSC_SEG_LSB]), // [RULE3]
		.pin_in(segment_address_port_in),
		.pin_out(segment_address_port_out),
		.pin_oe(segment_address_port_oe),
		.pin_value(port_value)
	);

	ebsc_fetch_strap u_strap (
		.mclk(mclk),
		.rstn(rstn),
		.external_fetch_select_n(external_fetch_select_n),
		.fetch_external(fetch_external)
	);

	always @* begin
		next_state = state;
		case (state)
			`EBSC_ST_IDLE: begin
				if (req)
					next_state = `EBSC_ST_ADDR;
			end
			`EBSC_ST_ADDR: begin
				next_state = `EBSC_ST_STROBE;
			end
			`EBSC_ST_STROBE: begin
				// ready high stretches the access [RULE8]
				if (ready_enable && ready)
					next_state = `EBSC_ST_WAIT;
				else
					next_state = `EBSC_ST_END;
			end
			`EBSC_ST_WAIT: begin
				if (!ready)
					next_state = `EBSC_ST_END; // [RULE8]
			end
			`EBSC_ST_END: begin
				next_state = `EBSC_ST_IDLE;
			end
			default: begin
				next_state = `EBSC_ST_IDLE;
			end
		endcase
	end

	always @(posedge mclk) begin
		if (!rstn) begin
			state <= `EBSC_ST_IDLE;
			op_write <= 1'b0;
			op_8bit <= 1'b0;
			op_bytes <= 2'h0;
			addr_out <= {AW{1'h0}};
			ale <= 1'h0;
			read_strobe_n <= 1'h1;
			low_byte_write_strobe_n <= 1'h1;
			high_byte_enable_n <= 1'h1;
			high_byte_write_strobe_n <= 1'h1;
			done <= 1'h0;
		end else begin
			state <= next_state;
			done <= (state == `EBSC_ST_END);
			if (state == `EBSC_ST_IDLE && req) begin
				// a fetch is always a read
				op_write <= req_write & ~req_fetch;
				op_8bit <= bus_8bit;
				op_bytes <= req_bytes;
				addr_out <= req_addr;
			end
			// address phase pulse, only when multiplexed [RULE9]
			ale <= (next_state == `EBSC_ST_ADDR) & bus_mux;
			if (next_state == `EBSC_ST_STROBE) begin
				read_strobe_n <= op_write; // [RULE4] [RULE12]
				low_byte_write_strobe_n <= ~(op_write &
					low_active(write_strobe_config, op_8bit, op_bytes));
				// high byte: enable in word mode, strobe in byte mode [RULE11]
				// two separate outputs, but the write strobe config bit keeps them from acting together
				high_byte_enable_n <= op_8bit | ~op_bytes[1] |
					(write_strobe_config == `EBSC_WRITE_STROBE_CONFIG_BYTE);
				high_byte_write_strobe_n <= ~(op_write & ~op_8bit &
					op_bytes[1] & (write_strobe_config == `EBSC_WRITE_STROBE_CONFIG_BYTE));
			end else if (next_state == `EBSC_ST_END ||
				next_state == `EBSC_ST_IDLE) begin
				read_strobe_n <= 1'h1;
				low_byte_write_strobe_n <= 1'h1;
				high_byte_enable_n <= 1'h1;
				high_byte_write_strobe_n <= 1'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== ebsc_bus_ctrl_tb.sv
// self-checking bench for the bus strobe controller
`timescale 1ns/1ns
`default_nettype none
module ebsc_bus_ctrl_tb;
	logic mclk = 0, rstn = 0, req = 0, req_write = 0, req_fetch = 0;
	logic bus_8bit = 0, bus_mux = 0, ready_enable = 0, ready, busy, done;
	logic external_fetch_select_n = 1, ale, read_strobe_n, fetch_external;
	logic low_byte_write_strobe_n, high_byte_enable_n;
	logic high_byte_write_strobe_n;
	logic [1:0] req_bytes = 0;
	logic [3:0] waits = 0;
	logic [15:0] system_config_register = 0;
	logic [23:0] req_addr = 24'hA51234, addr_out;
	logic [7:0] port_dir = 0, port_data = 8'h0F, seg_sel = 0, drv = 8'h5A;
	logic [7:0] segment_address_port_in, segment_address_port_out;
	logic [7:0] segment_address_port_oe, port_value;
	int n_fail = 0, n_checks = 0;
	ebsc_bus_ctrl i_dut (.*);
	ebsc_mem i_mem (.*);
	initial forever #20 mclk = ~mclk;
	task chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task conclude;
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task rst(input logic s);
		@(negedge mclk) rstn = 1'h0;
		external_fetch_select_n = s;
		repeat (2) @(negedge mclk);
		rstn = 1'h1;
		// strap moved after release must not count
		external_fetch_select_n = !s;
		repeat (2) @(negedge mclk);
		chk(fetch_external, !s);
	endtask
	// m = mux, ready on, fetch, write, byte mode, 8-bit, lanes
	task acc(input logic [7:0] m, input logic [3:0] nw, input logic [4:0] e);
		logic [4:0] seen;
		int n;
		seen = 5'h1F;
		n = 0;
		@(negedge mclk);
		{bus_mux, ready_enable, req_fetch, req_write} = m[7:4];
		system_config_register = {8'h00, m[3], 7'h00};
		{bus_8bit, req_bytes} = m[2:0];
		waits = nw;
		req = 1'h1;
		@(negedge mclk) req = 1'h0;
		while (done !== 1'h1 && n < 40) begin
			seen &= {!ale, read_strobe_n, low_byte_write_strobe_n,
				high_byte_enable_n, high_byte_write_strobe_n};
			n++;
			@(negedge mclk);
		end
		chk(seen, e);
		chk(n, m[6] ? 3 + nw : 3);
		chk(addr_out, 24'hA51234);
	endtask
	task port;
		@(negedge mclk);
		port_dir = 8'h03;
		seg_sel = 8'h30;
		repeat (3) @(negedge mclk);
		chk(segment_address_port_oe, 8'h33);
		chk(segment_address_port_out & 8'h33, 8'h23);
		chk(port_value, 8'h6B);
	endtask
	initial begin
		rst(1'h1);
		acc(8'hF3, 4'h0, 5'h05);
		acc(8'hD1, 4'h2, 5'h0B);
		acc(8'hDA, 4'h0, 5'h0E);
		acc(8'hDE, 4'h1, 5'h0B);
		acc(8'h01, 4'h3, 5'h17);
		acc(8'hD9, 4'h0, 5'h0B);
		port;
		rst(1'h0);
		conclude;
	end
	initial begin
		#20000;
		n_fail++;
		conclude;
	end
endmodule
bind ebsc_bus_ctrl ebsc_props i_props (.*);
`default_nettype wire

// ===== ebsc_defines.vh
// constants for the external bus strobe controller
`ifndef EBSC_DEFINES_VH
`define EBSC_DEFINES_VH
`define EBSC_PORT_W 8
`define EBSC_SEG_LSB 16
`define EBSC_SEG_MSB 23
`define EBSC_WRITE_STROBE_CONFIG_WORD 1'h0
`define EBSC_WRITE_STROBE_CONFIG_BYTE 1'h1
`define EBSC_WRITE_STROBE_CONFIG_BIT 7
`define EBSC_ST_IDLE 3'h0
`define EBSC_ST_ADDR 3'h1
`define EBSC_ST_STROBE 3'h2
`define EBSC_ST_WAIT 3'h3
`define EBSC_ST_END 3'h4
`define EBSC_ST_W 3
`endif

// ===== ebsc_fetch_strap.v
// captures the external fetch select level at reset release
`timescale 1ns/1ns
`default_nettype none
module ebsc_fetch_strap (
	input wire mclk,
	input wire rstn,
	input wire external_fetch_select_n,
	output reg fetch_external
);
	// sampled throughout reset, frozen after release [RULE10] [RULE12]
	always @(posedge mclk) begin
		if (!rstn) begin
			fetch_external <= ~external_fetch_select_n;
		end
	end
endmodule
`default_nettype wire

// ===== ebsc_mem.sv
// external memory model: ready and the pins it drives itself
`timescale 1ns/1ns
`default_nettype none
module ebsc_mem (
	input wire logic mclk, read_strobe_n, low_byte_write_strobe_n,
	input wire logic high_byte_write_strobe_n,
	input wire logic [7:0] segment_address_port_out, drv,
	input wire logic [7:0] segment_address_port_oe,
	input wire logic [3:0] waits,
	output logic ready,
	output logic [7:0] segment_address_port_in
);
	logic [3:0] cnt = 4'h0;
	wire act = !(read_strobe_n && low_byte_write_strobe_n
		&& high_byte_write_strobe_n);
	// pull-up keeps ready high outside accesses
	assign ready = !act || cnt < waits;
	always @(posedge mclk) cnt <= act ? cnt + 4'h1 : 4'h0;
	assign segment_address_port_in = segment_address_port_oe
		& segment_address_port_out | ~segment_address_port_oe & drv;
endmodule
`default_nettype wire

// ===== ebsc_props.sv
// assertions on the bus strobe controller ports
`timescale 1ns/1ns
`default_nettype none
module ebsc_props (
	input wire logic mclk, rstn, req, req_write, req_fetch, bus_8bit,
	input wire logic ready_enable, ready, external_fetch_select_n, ale,
	input wire logic read_strobe_n, low_byte_write_strobe_n, busy, done,
	input wire logic high_byte_enable_n,
	input wire logic high_byte_write_strobe_n, fetch_external,
	input wire logic [1:0] req_bytes,
	input wire logic [15:0] system_config_register,
	input wire logic [7:0] port_dir, seg_sel, segment_address_port_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire w16 = !req_fetch && req_write && !bus_8bit;
	wire bm = system_config_register[7];
	sequence s_go; !busy && req; endsequence
	property p_rd; s_go ##0 (req_fetch || !req_write)
		|=> ##1 !read_strobe_n; endproperty
	property p_he; s_go ##0 !bus_8bit && req_bytes[1] && !bm
		|=> ##1 !high_byte_enable_n; endproperty
	property p_hx; high_byte_enable_n || high_byte_write_strobe_n;
	endproperty
	property p_ww; s_go ##0 w16 && !bm |=> ##1 !low_byte_write_strobe_n;
	endproperty
	property p_bw; s_go ##0 w16 && bm && !req_bytes[0]
		|=> ##1 low_byte_write_strobe_n; endproperty
	property p_hb; s_go ##0 w16 && bm && req_bytes[1]
		|=> ##1 !high_byte_write_strobe_n; endproperty
	property p_ale; ale |=> !ale && busy; endproperty
	// ready is looked at two edges before done
	property p_wt; done |-> $past(!ready || !ready_enable, 2); endproperty
	property p_oe; $past(rstn) |->
		segment_address_port_oe == $past(port_dir | seg_sel); endproperty
	property p_fx; fetch_external == ($past(rstn) ? $past(fetch_external)
		: !$past(external_fetch_select_n)); endproperty
	a_rd: assert property (p_rd) else $error("no read strobe");
	a_ww: assert property (p_ww) else $error("no word write");
	a_bw: assert property (p_bw) else $error("bad low strobe");
	a_hb: assert property (p_hb) else $error("no high strobe");
	a_he: assert property (p_he) else $error("no high enable");
	a_hx: assert property (p_hx) else $error("high clash");
	a_ale: assert property (p_ale) else $error("bad latch pulse");
	a_wt: assert property (p_wt) else $error("wait ignored");
	a_oe: assert property (p_oe) else $error("bad enable");
	a_fx: assert property (p_fx) else $error("bad fetch");
endmodule
`default_nettype wire

// ===== ebsc_seg_port.v
// eight-pin bidirectional port with optional segment address output
`timescale 1ns/1ns
`default_nettype none
`include "ebsc_defines.vh"
module ebsc_seg_port #(
	parameter W = `EBSC_PORT_W
) (
	input wire mclk,
	input wire rstn,
	input wire [W-1:0] dir_out,
	input wire [W-1:0] port_data,
	input wire [W-1:0] seg_sel,
	input wire [W-1:0] seg_addr,
	input wire [W-1:0] pin_in,
	output reg [W-1:0] pin_out,
	output reg [W-1:0] pin_oe,
	output reg [W-1:0] pin_value
);
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_pin
			always @(posedge mclk) begin
				if (!rstn) begin
					pin_out[i] <= 1'h0;
					pin_oe[i] <= 1'h0;
					pin_value[i] <= 1'h0;
				end else begin
					// per-pin direction; input leaves driver off [RULE1] [RULE2]
					pin_oe[i] <= dir_out[i] | seg_sel[i];
					// bit i carries address bit 16+i [RULE3]
					pin_out[i] <= seg_sel[i] ? seg_addr[i] : port_data[i];
					pin_value[i] <= pin_in[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire
